//--- rtl/fps_pkg.sv
// Notes on behaviour
// - user base bits 19 to 11 are writable and set where user program space starts.
// - user base bits 10 to 0 read as zero and ignore writes, giving 2 KB steps.
// - user base bits 31 to 20 are unimplemented and read as zero.
// - any device reset clears the whole user program base register to zero.
// - program flash size is a read-only byte count of 16 KB to 256 KB in powers of two.
// - boot flash size is read-only and reads 0x00000C00, that is 3 KB.
// - erase pages are 1 KB (256 words) and program rows are 128 bytes (32 words).
`default_nettype none
package fps_pkg;
   localparam logic [3:0]  ADDR_USER_BASE  = 4'h0;
   localparam logic [3:0]  ADDR_PFM_SIZE   = 4'h4;
   localparam logic [3:0]  ADDR_BOOT_SIZE  = 4'h8;
   localparam logic [3:0]  ADDR_GEOMETRY   = 4'hC;
   localparam int          BASE_LSB        = 11;
   localparam int          BASE_MSB        = 19;
   localparam int          BASE_W          = BASE_MSB - BASE_LSB + 1;
   localparam logic [BASE_W-1:0] BASE_RESET = 9'h000;
   localparam logic [31:0] PFM_SIZE_DEF    = 32'h0004_0000;
   localparam logic [31:0] BOOT_SIZE       = 32'h0000_0C00;
   localparam logic [15:0] PAGE_BYTES      = 16'h0400;
   localparam logic [15:0] ROW_BYTES       = 16'h0080;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

   typedef struct packed {
      logic [BASE_W-1:0] base;
      logic              ack;
      logic [31:0]       dat;
      logic              err;
   } fps_state_s;
endpackage
`default_nettype wire

//--- rtl/fps_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fps_bus_if;
   logic        req;
   logic        we;
   logic [3:0]  adr;
   logic [31:0] wdat;
   logic [3:0]  sel;
   modport ctl (output req, output we, output adr, output wdat, output sel);
   modport regs (input req, input we, input adr, input wdat, input sel);
endinterface
`default_nettype wire

//--- rtl/fps_size_const.sv
`timescale 1ns/1ns
`default_nettype none
// constant size words; bus writes never reach them
module fps_size_const #(
   parameter logic [31:0] PFM_SIZE = fps_pkg::PFM_SIZE_DEF
) (
   output logic [31:0] pfm_size_o,
   output logic [31:0] boot_size_o,
   output logic [31:0] geometry_o
);
   assign pfm_size_o  = PFM_SIZE;
   assign boot_size_o = fps_pkg::BOOT_SIZE;
   assign geometry_o  = {fps_pkg::PAGE_BYTES, fps_pkg::ROW_BYTES};
endmodule
`default_nettype wire

//--- rtl/fps_regs.sv
`timescale 1ns/1ns
`default_nettype none
module fps_regs #(
   parameter logic [31:0] PFM_SIZE = fps_pkg::PFM_SIZE_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o,
   output logic [31:0]      user_base_o
);
   fps_bus_if bus ();
   fps_pkg::fps_state_s st;
   fps_pkg::fps_state_s next_st;
   logic [31:0] pfm_size;
   logic [31:0] boot_size;
   logic [31:0] geometry;

   fps_size_const #(.PFM_SIZE(PFM_SIZE)) u_const (
      .pfm_size_o  (pfm_size),
      .boot_size_o (boot_size),
      .geometry_o  (geometry)
   );

   function automatic logic mapped(input logic [31:0] a);
      mapped = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [31:0] base_word(input logic [fps_pkg::BASE_W-1:0] b);
      base_word = '0;
      base_word[fps_pkg::BASE_MSB:fps_pkg::BASE_LSB] = b;
   endfunction

   assign bus.req  = cyc_i && stb_i && !st.ack && !st.err;
   assign bus.we   = we_i;
   assign bus.adr  = adr_i[3:0];
   assign bus.wdat = dat_i;
   assign bus.sel  = sel_i;

   always_comb begin
      next_st     = st;
      next_st.ack = 1'b0;
      next_st.err = 1'b0;
      if (bus.req) begin
         if (mapped(adr_i)) begin
            next_st.ack = 1'b1;
            if (bus.we) begin
               // only user base is writable; size words ignore writes
               if (bus.adr == fps_pkg::ADDR_USER_BASE) begin
                  // field spans byte lanes 1 and 2
                  if (bus.sel[1]) begin
                     next_st.base[4:0] = bus.wdat[15:11];
                  end
                  if (bus.sel[2]) begin
                     next_st.base[8:5] = bus.wdat[19:16];
                  end
               end
            end else begin
               case (bus.adr)
                  fps_pkg::ADDR_USER_BASE: next_st.dat = base_word(st.base);
                  fps_pkg::ADDR_PFM_SIZE:  next_st.dat = pfm_size;
                  fps_pkg::ADDR_BOOT_SIZE: next_st.dat = boot_size;
                  fps_pkg::ADDR_GEOMETRY:  next_st.dat = geometry;
                  default:                 next_st.dat = fps_pkg::UNMAPPED_DATA;
               endcase
            end
         end else begin
            next_st.err = 1'b1;
            next_st.dat = fps_pkg::UNMAPPED_DATA;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.base <= fps_pkg::BASE_RESET;
         st.ack  <= 1'b0;
         st.err  <= 1'b0;
         st.dat  <= fps_pkg::UNMAPPED_DATA;
      end else begin
         st <= next_st;
      end
   end

   // bound against flash size is software's job; hardware stores any value
   assign dat_o       = st.dat;
   assign ack_o       = st.ack && cyc_i && stb_i;
   assign err_o       = st.err && cyc_i && stb_i;
   assign user_base_o = base_word(st.base);
endmodule
`default_nettype wire

//--- dv/fps_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module fps_regs_props #(parameter logic [31:0] PFM_SIZE = fps_pkg::PFM_SIZE_DEF) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic [31:0] user_base_o,
   input wire logic [3:0]  sel_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_base_pad_zero: assert property (user_base_o[10:0] == 11'h0 && user_base_o[31:20] == 12'h0)
      else $error("base pad bits set");
   a_base_reset: assert property ($past(rst_i) |-> user_base_o == 32'h0)
      else $error("base not cleared");
   a_base_write: assert property (ack_o && $past(we_i && adr_i == 32'h0 && sel_i == 4'hF) |->
      user_base_o[19:11] == $past(dat_i[19:11])) else $error("base write lost");
   a_base_read: assert property (ack_o && $past(!we_i && adr_i == 32'h0) |-> dat_o == user_base_o)
      else $error("base read wrong");
   a_pfm_read: assert property (ack_o && $past(!we_i && adr_i == 32'h4) |->
      dat_o == PFM_SIZE) else $error("flash size wrong");
   a_boot_read: assert property (ack_o && $past(!we_i && adr_i == 32'h8) |->
      dat_o == 32'h0000_0C00) else $error("boot size wrong");
   a_geom_read: assert property (ack_o && $past(!we_i && adr_i == 32'hC) |->
      dat_o == 32'h0400_0080) else $error("geometry wrong");
   a_ro_write: assert property (ack_o && $past(we_i && adr_i != 32'h0) |-> $stable(user_base_o))
      else $error("base moved");
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, err_o, er;
   logic [31:0] adr_i = 0, dat_i = 0, dat_o, user_base_o, q;
   logic [3:0]  sel_i = 0;
   int          num_errors = 0, checks = 0;
   fps_regs uut (.*);
   initial forever #10 clk_i = ~clk_i;
   task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      q = dat_o;
      er = err_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task automatic rd(input logic [31:0] a, e);
      wb(1'b0, a, 32'h0, 4'hF);
      checks++;
      if (q !== e || er !== (a > 32'hC)) begin
         num_errors++;
         $display("unexpected %0t read %h got %h", $time, a, q);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000 num_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      rd(32'h0, 32'h0);
      wb(1'b1, 32'h0, 32'hFFF3_FFFF, 4'hF);
      rd(32'h0, 32'h0003_F800);
      wb(1'b1, 32'h0, 32'h0, 4'h4);
      rd(32'h0, 32'h0000_F800);
      $display("test base done");
      for (int i = 4; i <= 12; i += 4) wb(1'b1, 32'(i), '1, 4'hF);
      rd(32'h4, fps_pkg::PFM_SIZE_DEF);
      rd(32'h8, 32'h0000_0C00);
      rd(32'hC, 32'h0400_0080);
      rd(32'h10, 32'h0);
      $display("test sizes done");
      rst_i <= 1;
      @(posedge clk_i);
      rst_i <= 0;
      rd(32'h0, 32'h0);
      $display("test reset done");
      tally_and_finish;
   end
endmodule
bind fps_regs fps_regs_props #(.PFM_SIZE(PFM_SIZE)) props_i (.*);
`default_nettype wire
